// ### flash_guard_pkg.sv
// Constants and types for the flash rewrite protection block
// Notes on behaviour
// - A written location refuses a second write until its block is erased
// - Boot mode at reset: mode strap high, and primary high or alternate high with select low
// - CPU rewrite of blocks 0 and 1 needs low-block and blocks-0-to-3 enables
// - CPU rewrite of blocks 2 and 3 needs only the blocks-0-to-3 enable
// - In CPU mode data blocks A and B are reachable only with data-area access enabled
// - Protection armed when protect field is not 11 and low six bits are ones
// - Armed protection refuses reads and changes in parallel programmer mode
// - Only erasing the protect block, by CPU or serial programmer, disarms it
// - Erasing the protect block leaves the protect byte at FF
// - Protect byte 00 or FF leaves protection disabled
// - Serial mode compares seven received identifier bytes with stored ones unless blank
// - After an identifier mismatch every later serial command is ignored until the next reset
// - Identifier bytes sit at fixed block 0 addresses between vector locations
// - Low-block enable counts only while CPU rewrite enable is set
package flash_guard_pkg;

  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned DEPTH   = 128;
  localparam int unsigned ID_LEN  = 7;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_CMD    = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IDRX   = 8'h14;

  // Control bit positions
  localparam int unsigned CTRL_CPU_EN   = 0;
  localparam int unsigned CTRL_LOW_EN   = 1;
  localparam int unsigned CTRL_B03_EN   = 2;
  localparam int unsigned CTRL_DATA_EN  = 3;
  localparam int unsigned CTRL_FLASH_EW = 4;
  localparam int unsigned CTRL_UART     = 5;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;

  // ********************************************************
  // Flash layout
  // ********************************************************
  localparam logic [2:0]        BLK_DATA_A = 3'h6;
  localparam logic [2:0]        BLK_DATA_B = 3'h7;
  localparam logic [ADDR_W-1:0] PROT_ADDR  = 7'h0F;
  localparam logic [7:0]        ERASED     = 8'hFF;
  localparam logic [1:0]        FIELD_OFF  = 2'h3;
  localparam logic [5:0]        LOW_ONES   = 6'h3F;

  typedef enum logic [2:0] {
    OP_NONE  = 3'h0,
    OP_PROG  = 3'h1,
    OP_ERASE = 3'h2,
    OP_READ  = 3'h3,
    OP_IDCHK = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    MODE_CPU      = 2'b00,
    MODE_SERIAL   = 2'b01,
    MODE_PARALLEL = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    ST_SYNC1 = 2'b00,
    ST_SYNC2 = 2'b01,
    ST_RUN   = 2'b11
  } boot_st_t;

endpackage

// ### flash_guard.sv
// Flash rewrite protection: mode entry, rewrite gating, protect and ID check
`timescale 1ns/1ps
module flash_guard
  import flash_guard_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Straps sampled after reset
  input  wire logic        processor_mode_strap,
  input  wire logic        boot_strap_primary,
  input  wire logic        boot_strap_alternate,
  input  wire logic        boot_select_strap,
  input  wire logic        parallel_mode_strap,
  // Status
  output logic             boot_mode,
  output logic             protect_armed,
  output logic             serial_locked,
  output logic [1:0]       access_mode
);

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [2:0] blk_of(input logic [ADDR_W-1:0] a);
    return a[6:4];
  endfunction

  function automatic logic armed_of(input logic [7:0] b);
    return (b[7:6] != FIELD_OFF) && (b[5:0] == LOW_ONES);
  endfunction

  // ID bytes interleave with vectors in block 0
  function automatic logic [ADDR_W-1:0] id_addr(input int unsigned k);
    return 7'((k << 1) + 1);
  endfunction

  // ********************************************************
  // State
  // ********************************************************
  // Flash starts blank and keeps its contents through every reset
  logic [7:0]        mem_r     [DEPTH] = '{default: ERASED};
  logic [DEPTH-1:0]  written_r = '0;
  logic [7:0]        id_rx_r   [ID_LEN];
  logic [4:0]        strap_s1_r;
  logic [4:0]        strap_s2_r;
  boot_st_t          boot_st_r;
  mode_t             mode_r;
  logic              boot_mode_r;
  logic              armed_r;
  logic              blank_r;
  logic              id_ok_r;
  logic              locked_r;
  logic              eval_r;
  logic [5:0]        ctrl_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        wdata_r;
  logic              done_r;
  logic              refused_r;
  logic [7:0]        rdata_r;
  logic              pready_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;

  logic              wr_acc;
  logic              cmd_go;
  op_t               cmd_op;
  logic              allow;
  logic              id_match;
  logic              blank_c;
  logic              boot_dec;
  logic              capture;
  logic [2:0]        blk;
  logic              is_data;

  assign pready        = pready_r;
  assign prdata        = prdata_r;
  assign pslverr       = pslverr_r;
  assign boot_mode     = boot_mode_r;
  assign protect_armed = armed_r;
  assign serial_locked = locked_r;
  assign access_mode   = mode_r;

  // ********************************************************
  // Strap capture
  // ********************************************************
  // No reset here: straps held during reset already fill both stages,
  // so the capture two edges after release sees the real pin levels
  always_ff @(posedge pclk) begin
    strap_s1_r <= {parallel_mode_strap, boot_select_strap,
                   boot_strap_alternate, boot_strap_primary,
                   processor_mode_strap};
    strap_s2_r <= strap_s1_r;
  end

  assign boot_dec = strap_s2_r[0] & (strap_s2_r[1] |
                    (strap_s2_r[2] & ~strap_s2_r[3]));
  assign capture  = (boot_st_r == ST_SYNC2);

  // Straps count only once, after the synchroniser has filled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_st_r   <= ST_SYNC1;
      boot_mode_r <= 1'b0;
      mode_r      <= MODE_CPU;
    end else begin
      case (boot_st_r)
        ST_SYNC1: begin
          boot_st_r <= ST_SYNC2;
        end
        ST_SYNC2: begin
          boot_st_r   <= ST_RUN;
          boot_mode_r <= boot_dec;
          if (strap_s2_r[4]) begin
            mode_r <= MODE_PARALLEL;
          end else if (boot_dec) begin
            mode_r <= MODE_SERIAL;
          end else begin
            mode_r <= MODE_CPU;
          end
        end
        default: begin
          boot_st_r <= ST_RUN;
        end
      endcase
    end
  end

  // ********************************************************
  // APB slave, zero wait: pready rises in the access phase
  // ********************************************************
  assign wr_acc = psel & penable & pready_r & pwrite;
  assign cmd_go = wr_acc & (paddr == OFF_CMD);
  assign cmd_op = op_t'(pwdata[2:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        if (paddr == OFF_CTRL) begin
          prdata_r <= {26'h000_0000, ctrl_r};
        end else if (paddr == OFF_ADDR) begin
          prdata_r <= {25'h000_0000, addr_r};
        end else if (paddr == OFF_WDATA) begin
          prdata_r <= {24'h00_0000, wdata_r};
        end else if (paddr == OFF_CMD) begin
          prdata_r <= 32'h0000_0000;
        end else if (paddr == OFF_STATUS) begin
          prdata_r <= {8'h00, rdata_r, 6'h00, mode_r, 1'b0,
                       boot_mode_r, blank_r, locked_r, id_ok_r,
                       armed_r, refused_r, done_r};
        end else if (paddr == OFF_IDRX) begin
          prdata_r <= 32'h0000_0000;
        end else begin
          pslverr_r <= 1'b1;
        end
      end else if (psel & ~penable) begin
        pslverr_r <= !((paddr == OFF_CTRL) || (paddr == OFF_ADDR) ||
                       (paddr == OFF_WDATA) || (paddr == OFF_CMD) ||
                       (paddr == OFF_IDRX));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= CTRL_RESET;
      addr_r  <= 7'h00;
      wdata_r <= 8'h00;
    end else if (wr_acc) begin
      if (paddr == OFF_CTRL) begin
        ctrl_r <= pwdata[5:0];
      end else if (paddr == OFF_ADDR) begin
        addr_r <= pwdata[ADDR_W-1:0];
      end else if (paddr == OFF_WDATA) begin
        wdata_r <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < ID_LEN; k++) begin
        id_rx_r[k] <= 8'h00;
      end
    end else if (wr_acc && (paddr == OFF_IDRX) &&
                 (pwdata[10:8] < 3'(ID_LEN))) begin
      id_rx_r[pwdata[10:8]] <= pwdata[7:0];
    end
  end

  // ********************************************************
  // Access permission
  // ********************************************************
  assign blk     = blk_of(addr_r);
  assign is_data = (blk == BLK_DATA_A) || (blk == BLK_DATA_B);

  always_comb begin
    allow = 1'b0;
    case (mode_r)
      MODE_CPU: begin
        if (is_data && !ctrl_r[CTRL_DATA_EN]) begin
          allow = 1'b0;
        end else if (cmd_op == OP_READ) begin
          allow = 1'b1;
        end else if (!ctrl_r[CTRL_CPU_EN]) begin
          allow = 1'b0;
        end else if (blk < 3'h2) begin
          allow = ctrl_r[CTRL_LOW_EN] & ctrl_r[CTRL_B03_EN];
        end else if (blk < 3'h4) begin
          allow = ctrl_r[CTRL_B03_EN];
        end else begin
          allow = 1'b1;
        end
      end
      MODE_SERIAL: begin
        allow = (blank_r | id_ok_r) & ~locked_r;
      end
      default: begin
        allow = ~armed_r;
      end
    endcase
    if (cmd_op == OP_PROG && written_r[addr_r]) begin
      allow = 1'b0;
    end
    if (cmd_op == OP_IDCHK || cmd_op == OP_NONE) begin
      allow = 1'b0;
    end
  end

  always_comb begin
    id_match = 1'b1;
    for (int k = 0; k < ID_LEN; k++) begin
      if (id_rx_r[k] != mem_r[id_addr(k)]) begin
        id_match = 1'b0;
      end
    end
  end

  always_comb begin
    blank_c = 1'b1;
    for (int i = 0; i < DEPTH; i++) begin
      if (mem_r[i] != ERASED) begin
        blank_c = 1'b0;
      end
    end
  end

  // ********************************************************
  // Flash array
  // ********************************************************
  // Non-volatile: reset must not touch the array, or protection and the
  // identifier would be lost before they are evaluated
  always_ff @(posedge pclk) begin
    if (cmd_go && allow) begin
      if (cmd_op == OP_PROG) begin
        mem_r[addr_r]     <= wdata_r;
        written_r[addr_r] <= 1'b1;
      end else if (cmd_op == OP_ERASE) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (blk_of(7'(i)) == blk) begin
            mem_r[i]     <= ERASED;
            written_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      rdata_r   <= 8'h00;
    end else if (cmd_go) begin
      done_r    <= allow | (cmd_op == OP_IDCHK);
      refused_r <= ~allow & (cmd_op != OP_IDCHK);
      if (allow && cmd_op == OP_READ) begin
        rdata_r <= mem_r[addr_r];
      end
    end
  end

  // ********************************************************
  // Protect and identifier decisions
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_r <= 1'b0;
    end else begin
      eval_r <= capture | (cmd_go & allow & (cmd_op == OP_ERASE));
    end
  end

  // Arming follows a fresh evaluation, not a plain program of the byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
      blank_r <= 1'b1;
    end else if (eval_r) begin
      armed_r <= armed_of(mem_r[PROT_ADDR]);
      blank_r <= blank_c;
    end
  end

  // A mismatch locks the serial port until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_ok_r  <= 1'b0;
      locked_r <= 1'b0;
    end else if (cmd_go && cmd_op == OP_IDCHK &&
                 mode_r == MODE_SERIAL && !locked_r) begin
      if (blank_r || id_match) begin
        id_ok_r <= 1'b1;
      end else begin
        id_ok_r  <= 1'b0;
        locked_r <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_no_overwrite;
    cmd_go && cmd_op == OP_PROG && written_r[addr_r] |=> refused_r;
  endproperty
  a_no_overwrite: assert property (p_no_overwrite)
    else $error("second write to a written location was taken");

  property p_boot_entry;
    capture |=> boot_mode_r == $past(boot_dec);
  endproperty
  a_boot_entry: assert property (p_boot_entry)
    else $error("boot mode does not follow the straps");

  property p_low_blocks;
    cmd_go && mode_r == MODE_CPU && blk < 3'h2 &&
    (cmd_op == OP_ERASE || cmd_op == OP_PROG) &&
    !(ctrl_r[CTRL_LOW_EN] && ctrl_r[CTRL_B03_EN] && ctrl_r[CTRL_CPU_EN])
    |=> refused_r && written_r == $past(written_r);
  endproperty
  a_low_blocks: assert property (p_low_blocks)
    else $error("low block changed without both enables");

  property p_mid_blocks;
    cmd_go && mode_r == MODE_CPU &&
    (cmd_op == OP_ERASE || (cmd_op == OP_PROG && !written_r[addr_r])) &&
    (blk == 3'h2 || blk == 3'h3) && ctrl_r[CTRL_CPU_EN] &&
    ctrl_r[CTRL_B03_EN] |=> done_r && !refused_r;
  endproperty
  a_mid_blocks: assert property (p_mid_blocks)
    else $error("block 2 or 3 erase refused with enable set");

  property p_data_area;
    cmd_go && mode_r == MODE_CPU && is_data && !ctrl_r[CTRL_DATA_EN]
    && cmd_op != OP_IDCHK |=> refused_r;
  endproperty
  a_data_area: assert property (p_data_area)
    else $error("data block reached without access enable");

  property p_arm_eval;
    eval_r |=> armed_r == armed_of($past(mem_r[PROT_ADDR]));
  endproperty
  a_arm_eval: assert property (p_arm_eval)
    else $error("protect state does not follow protect byte");

  property p_parallel_block;
    cmd_go && mode_r == MODE_PARALLEL && armed_r |=> refused_r ##1
    $stable(rdata_r);
  endproperty
  a_parallel_block: assert property (p_parallel_block)
    else $error("parallel access passed while protected");

  property p_erase_ff;
    cmd_go && allow && cmd_op == OP_ERASE && blk == 3'h0
    |=> mem_r[PROT_ADDR] == ERASED ##2 !armed_r;
  endproperty
  a_erase_ff: assert property (p_erase_ff)
    else $error("protect byte not FF or still armed after erase");

  property p_serial_lock;
    locked_r && mode_r == MODE_SERIAL && cmd_go && cmd_op != OP_IDCHK
    |=> refused_r;
  endproperty
  a_serial_lock: assert property (p_serial_lock)
    else $error("serial command taken after mismatch");

  c_boot: cover property (capture && boot_dec);
  c_lock: cover property (cmd_go && cmd_op == OP_IDCHK && !id_match &&
                          !blank_r && mode_r == MODE_SERIAL);
  c_armed: cover property ($rose(armed_r));

endmodule

// ### flash_host.sv
// APB master model standing in for the CPU or programmer side
`timescale 1ns/1ps
module flash_host
  import flash_guard_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ********************************************************
  // Bus cycles
  // ********************************************************
  // Request held until pready is seen high; no wait count assumed
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, a, d, q, e);
  endtask

  // Any block can be addressed, including block 0 with its vector and identifier locations
  // Erase of the protect block is issued through this path too
  task automatic cmd(input logic [2:0] op, input logic [6:0] a,
                     input logic [7:0] d);
    wr(OFF_ADDR, {25'h000_0000, a});
    wr(OFF_WDATA, {24'h00_0000, d});
    wr(OFF_CMD, {29'h0000_0000, op});
  endtask
endmodule

// ### flash_rewrite_protection_tb.sv
// Self-checking bench for the flash rewrite protection block
`timescale 1ns/1ps
module flash_rewrite_protection_tb
  import flash_guard_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        processor_mode_strap, boot_strap_primary;
  logic        boot_strap_alternate, boot_select_strap, parallel_mode_strap;
  logic        boot_mode, protect_armed, serial_locked;
  logic [1:0]  access_mode;
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          seed = 87535;
  // ********************************************************
  // Reference model state
  // ********************************************************
  logic [7:0]  mem [DEPTH];
  bit          wrt [DEPTH];
  logic [7:0]  idb [ID_LEN];
  logic [5:0]  ctrl;
  logic [1:0]  md;
  bit          armed, blank, locked, idok, boot;
  logic [31:0] q;
  logic        e;

  always #2 pclk = ~pclk;

  flash_guard i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .processor_mode_strap(processor_mode_strap),
    .boot_strap_primary(boot_strap_primary),
    .boot_strap_alternate(boot_strap_alternate),
    .boot_select_strap(boot_select_strap),
    .parallel_mode_strap(parallel_mode_strap), .boot_mode(boot_mode),
    .protect_armed(protect_armed), .serial_locked(serial_locked),
    .access_mode(access_mode));

  flash_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic conclude;
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard: whole sequence needs only a few hundred cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  function automatic void eval();
    armed = mem[PROT_ADDR][7:6] !== FIELD_OFF &&
            mem[PROT_ADDR][5:0] === LOW_ONES;
    blank = 1;
    foreach (mem[i]) if (mem[i] !== ERASED) blank = 0;
  endfunction

  // Straps as {mode, primary, alternate, select, parallel}
  task automatic restart(input logic [4:0] s);
    @(posedge pclk);
    presetn <= 1'b0;
    {processor_mode_strap, boot_strap_primary, boot_strap_alternate,
     boot_select_strap, parallel_mode_strap} <= s;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    boot = s[4] & (s[3] | (s[2] & ~s[1]));
    md = s[0] ? MODE_PARALLEL : (boot ? MODE_SERIAL : MODE_CPU);
    ctrl = CTRL_RESET;
    locked = 0;
    idok = 0;
    eval();
    chk("boot_mode", boot, boot_mode);
    chk("access_mode", md, access_mode);
    chk("protect_armed", armed, protect_armed);
  endtask

  task automatic setc(input logic [5:0] v);
    i_host.wr(OFF_CTRL, {26'h000_0000, v});
    ctrl = v;
  endtask

  task automatic run(input op_t op, input logic [6:0] a,
                     input logic [7:0] d);
    bit         y;
    logic [2:0] b;
    b = a[6:4];
    case (md)
      MODE_PARALLEL: y = !armed;
      MODE_SERIAL:   y = !locked && (blank || idok);
      default: begin
        if (b >= BLK_DATA_A)
          y = ctrl[CTRL_DATA_EN] && (op == OP_READ || ctrl[CTRL_CPU_EN]);
        else
          y = op == OP_READ || ctrl[CTRL_CPU_EN] && (b > 3 ||
              ctrl[CTRL_B03_EN] && (b > 1 || ctrl[CTRL_LOW_EN]));
      end
    endcase
    if (op == OP_PROG && wrt[a]) y = 0;
    i_host.cmd(op, a, d);
    i_host.xfer(1'b0, OFF_STATUS, 32'h0000_0000, q, e);
    chk("done", y, q[0]);
    chk("refused", !y, q[1]);
    if (y && op == OP_READ) chk("rdata", mem[a], q[23:16]);
    if (y && op == OP_PROG) begin
      mem[a] = d;
      wrt[a] = 1;
    end
    if (y && op == OP_ERASE) begin
      for (int i = 0; i < 16; i++) begin
        mem[{b, 4'(i)}] = ERASED;
        wrt[{b, 4'(i)}] = 0;
      end
      eval();
    end
    chk("protect_armed", armed, protect_armed);
  endtask

  task automatic idchk(input logic [7:0] bad);
    for (int k = 0; k < ID_LEN; k++)
      i_host.wr(OFF_IDRX, {21'h00_0000, 3'(k),
                           idb[k] ^ (k == 3 ? bad : 8'h00)});
    i_host.wr(OFF_CMD, {29'h0000_0000, OP_IDCHK});
    if (blank || bad == 8'h00) idok = 1;
    else locked = 1;
    i_host.xfer(1'b0, OFF_STATUS, 32'h0000_0000, q, e);
    chk("serial_locked", locked, serial_locked);
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    {processor_mode_strap, boot_strap_primary, boot_strap_alternate,
     boot_select_strap, parallel_mode_strap} = 5'h00;
    foreach (mem[i]) mem[i] = ERASED;
    foreach (wrt[i]) wrt[i] = 0;
    restart(5'h00);
    i_host.xfer(1'b0, OFF_CTRL, 32'h0000_0000, q, e);
    chk("ctrl_reset", 32'h0000_0000, q);
    i_host.xfer(1'b0, 8'h18, 32'h0000_0000, q, e);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 32'h0000_0000, q);
    setc(6'h05);
    run(OP_PROG, 7'h20, 8'($random(seed)));
    run(OP_PROG, 7'h01, 8'h11);
    setc(6'h06);
    run(OP_PROG, 7'h01, 8'h11);
    setc(6'h07);
    for (int k = 0; k < ID_LEN; k++) begin
      idb[k] = 8'($random(seed));
      run(OP_PROG, 7'(1 + 2 * k), idb[k]);
    end
    run(OP_PROG, 7'h01, 8'h22);
    run(OP_PROG, 7'h60, 8'h33);
    setc(6'h0F);
    run(OP_PROG, 7'h60, 8'($random(seed)));
    run(OP_READ, 7'h60, 8'h00);
    run(OP_PROG, PROT_ADDR, 8'h7F);
    restart(5'h01);
    run(OP_READ, 7'h20, 8'h00);
    run(OP_ERASE, 7'h00, 8'h00);
    restart(5'h18);
    idchk(8'h5A);
    run(OP_READ, 7'h03, 8'h00);
    restart(5'h14);
    idchk(8'h00);
    run(OP_READ, 7'h03, 8'h00);
    run(OP_ERASE, 7'h00, 8'h00);
    restart(5'h16);
    run(OP_READ, PROT_ADDR, 8'h00);
    setc(6'h07);
    run(OP_PROG, PROT_ADDR, 8'h00);
    restart(5'h01);
    run(OP_READ, 7'h20, 8'h00);
    conclude();
  end
endmodule
